// >>> rtl/aux_monitor_cfg.svh
// Purpose: constants for the AUX link training monitor
// Assumes: 40 MHz clk_sys, 1 Mbps Manchester AUX signalling
// Notes: offsets are DPCD byte addresses on the AUX channel
//
// Functional notes
// - Derive swing, pre-emphasis, EQ from training writes
// - Decode 1 Mbps Manchester AUX traffic
// - Monitor inactive in TMDS (adapter detect high)
// - Watch AUX traffic for D3 standby command
// - Writes to reserved bit fields have no effect
// - Rate code 06h is 1.62, 14h is 5.4
// - Rate defaults to 2.7; 0Ah selects it
// - Any other rate code falls back to 5.4
// - Rate reads back as compressed 00h/01h/02h
// - Lane count bits 4:0, codes 0/1/2/4, default off
// - Other lane count codes disable every lane
// - Lane count reads back 00h/01h/03h/05h
// - Lane-0 bits 1:0 pick swing level, default 0
// - Lane-0 bits 4:3 pick pre-emphasis, default 0
// - Lane-0 reads: pre-emphasis 3:2, swing 1:0
// - Test-force bit forces TMDS without adapter detect
// - EQ follows pre-emphasis only, not swing
`ifndef AUX_MONITOR_CFG_SVH
`define AUX_MONITOR_CFG_SVH

`define CLK_PERIOD_NS 25
`define AUX_BIT_NS 1000
`define AUX_BIT_CYC (`AUX_BIT_NS / `CLK_PERIOD_NS)
`define AUX_HOLD_MID_CYC ((`AUX_BIT_CYC * 3) / 4)
`define AUX_HOLD_SYNC_CYC ((`AUX_BIT_CYC * 9) / 4)
`define AUX_SYNC_HIGH_CYC ((`AUX_BIT_CYC * 3) / 2)
`define AUX_IDLE_CYC (`AUX_BIT_CYC * 4)

`define ADDR_LINK_RATE 20'h00100
`define ADDR_LANE_COUNT 20'h00101
`define ADDR_LANE0_DRIVE 20'h00103
`define ADDR_POWER_STATE 20'h00600

`define CMD_NATIVE_WRITE 4'h8
`define POWER_D0 3'h1
`define POWER_D3 3'h2

`define RATE_WR_162 8'h06
`define RATE_WR_270 8'h0A
`define RATE_WR_540 8'h14
`define RATE_RD_162 8'h00
`define RATE_RD_270 8'h01
`define RATE_RD_540 8'h02

`define LANES_WR_0 5'h00
`define LANES_WR_1 5'h01
`define LANES_WR_2 5'h02
`define LANES_WR_4 5'h04
`define LANES_RD_0 8'h00
`define LANES_RD_1 8'h01
`define LANES_RD_2 8'h03
`define LANES_RD_4 8'h05

`define LANE_COUNT_RESET 5'h00
`define DRIVE_LEVEL_RESET 2'h0
`define LANE_COUNT_MSB 4
`define SWING_MSB 1
`define SWING_LSB 0
`define PRE_MSB 4
`define PRE_LSB 3

`endif

// >>> rtl/aux_monitor_pkg.sv
// Purpose: shared types of the AUX link training monitor
// Assumes: nothing beyond the cfg header
// Notes: states and link rates only
package aux_monitor_pkg;

    typedef enum logic [1:0] {
        RATE_162,
        RATE_270,
        RATE_540
    } link_rate_e;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_HDR,
        FR_DATA,
        FR_SKIP
    } frame_state_e;

endpackage

// >>> rtl/pin_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    stage1_r[i] <= 1'b0;
                    stage2_r[i] <= 1'b0;
                    stage3_r[i] <= 1'b0;
                    pinOut[i] <= 1'b0;
                end else begin
                    stage1_r[i] <= pinIn[i];
                    stage2_r[i] <= stage1_r[i];
                    stage3_r[i] <= stage2_r[i];
                    // one-cycle glitches never reach the filtered output
                    if (stage2_r[i] == stage3_r[i]) begin
                        pinOut[i] <= stage3_r[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// >>> rtl/aux_manchester_decoder.sv
// Purpose: edge-timed Manchester bit recovery for the AUX line
// Assumes: synchronised line level, bit value is second-half level
// Notes: frameMark fires on each sync/stop high-then-low pattern
`timescale 1ns/1ps
`include "aux_monitor_cfg.svh"
module aux_manchester_decoder (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic lineLevel,
    output logic bitStrobe,
    output logic bitValue,
    output logic frameMark,
    output logic idleTimeout
);

    logic lineDly_r;
    logic [7:0] highCnt_r;
    logic [7:0] hold_r;
    logic [7:0] quiet_r;
    logic edgeSeen;
    logic syncFall;

    assign edgeSeen = lineLevel ^ lineDly_r;
    // a high lasting well over one bit can only be a sync or stop
    assign syncFall = edgeSeen && !lineLevel && (highCnt_r >= 8'(`AUX_SYNC_HIGH_CYC));

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lineDly_r <= 1'b0;
            highCnt_r <= 8'h00;
            quiet_r <= 8'h00;
        end else begin
            lineDly_r <= lineLevel;
            if (!lineLevel) begin
                highCnt_r <= 8'h00;
            end else if (highCnt_r != 8'hFF) begin
                highCnt_r <= highCnt_r + 8'h01;
            end
            if (edgeSeen) begin
                quiet_r <= 8'h00;
            end else if (quiet_r != 8'hFF) begin
                quiet_r <= quiet_r + 8'h01;
            end
        end
    end

    // mid-bit edges are taken only after 3/4 bit; the sync low gets a
    // longer hold so its trailing boundary edge is skipped
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !enable) begin
            hold_r <= 8'h00;
        end else if (syncFall) begin
            hold_r <= 8'(`AUX_HOLD_SYNC_CYC);
        end else if (edgeSeen && hold_r == 8'h00) begin
            hold_r <= 8'(`AUX_HOLD_MID_CYC);
        end else if (hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
        end
    end

    // receive-only: there is no path back onto the line
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bitStrobe <= 1'b0;
            bitValue <= 1'b0;
            frameMark <= 1'b0;
            idleTimeout <= 1'b0;
        end else begin
            bitStrobe <= enable && edgeSeen && !syncFall && hold_r == 8'h00;
            bitValue <= lineLevel;
            frameMark <= enable && syncFall;
            idleTimeout <= enable && !edgeSeen && quiet_r == 8'(`AUX_IDLE_CYC);
        end
    end

endmodule

// >>> rtl/aux_link_training_monitor.sv
// Purpose: snoop AUX training writes and drive main-link settings
// Assumes: AUX request and reply both seen on one snooped line
// Notes: read codes are presented on ports; AUX is never driven
`timescale 1ns/1ps
`include "aux_monitor_cfg.svh"
module aux_link_training_monitor
    import aux_monitor_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic auxLineIn,
    input wire logic cableAdapterDetectInput,
    input wire logic tmdsTestForce,
    output link_rate_e linkRateSelect,
    output logic [7:0] linkRateReadCode,
    output logic [7:0] laneCountReadCode,
    output logic [7:0] lane0ReadCode,
    output logic [3:0] laneEnable,
    output logic [1:0] outputSwingLevel,
    output logic [1:0] preEmphasisLevel,
    output logic [1:0] inputEqualizerSetting,
    output logic standbyRequest,
    output logic tmdsMode,
    output logic monitorActive
);

    ////////////////////////////////////////////////////////////////
    // pin synchronisers and mode selection

    logic [1:0] pinsSync;
    logic auxLevel;
    logic cadLevel;
    logic tmdsNow;
    logic forceSync_r;

    pin_sync3 #(
        .WIDTH(2)
    ) u_pins (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn({cableAdapterDetectInput, auxLineIn}),
        .pinOut(pinsSync)
    );

    assign auxLevel = pinsSync[0];
    assign cadLevel = pinsSync[1];

    // test-force comes from on-chip logic on clk_sys, so one flop only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            forceSync_r <= 1'b0;
        end else begin
            forceSync_r <= tmdsTestForce;
        end
    end

    assign tmdsNow = cadLevel || forceSync_r;

    ////////////////////////////////////////////////////////////////
    // Manchester bit recovery

    logic bitStrobe;
    logic bitValue;
    logic frameMark;
    logic idleTimeout;

    aux_manchester_decoder u_dec (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enable(!tmdsNow),
        .lineLevel(auxLevel),
        .bitStrobe(bitStrobe),
        .bitValue(bitValue),
        .frameMark(frameMark),
        .idleTimeout(idleTimeout)
    );

    ////////////////////////////////////////////////////////////////
    // byte assembly, MSB first

    logic [7:0] shift_r;
    logic [2:0] bitCnt_r;
    logic byteDone;
    logic [7:0] byteData;

    assign byteDone = bitStrobe && bitCnt_r == 3'h7;
    assign byteData = {shift_r[6:0], bitValue};

    // a partial byte before a stop mark is dropped, never committed
    always_ff @(posedge clk_sys) begin
        if (!rst_b || tmdsNow || frameMark) begin
            shift_r <= 8'h00;
            bitCnt_r <= 3'h0;
        end else if (bitStrobe) begin
            shift_r <= byteData;
            bitCnt_r <= bitCnt_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // request frame parser

    frame_state_e state_r;
    logic [1:0] hdrIdx_r;
    logic [3:0] cmd_r;
    logic [19:0] addr_r;
    logic wrEn;
    logic [19:0] wrAddr;
    logic [7:0] wrData;

    assign wrEn = state_r == FR_DATA && byteDone;
    assign wrAddr = addr_r;
    assign wrData = byteData;

    // replies and native reads fall into skip; only writes reach data
    always_ff @(posedge clk_sys) begin
        if (!rst_b || tmdsNow) begin
            state_r <= FR_IDLE;
        end else if (idleTimeout) begin
            state_r <= FR_IDLE;
        end else begin
            case (state_r)
                FR_IDLE: begin
                    if (frameMark) begin
                        state_r <= FR_HDR;
                    end
                end
                FR_HDR: begin
                    if (frameMark) begin
                        state_r <= FR_IDLE;
                    end else if (byteDone && hdrIdx_r == 2'h3) begin
                        if (cmd_r == `CMD_NATIVE_WRITE) begin
                            state_r <= FR_DATA;
                        end else begin
                            state_r <= FR_SKIP;
                        end
                    end
                end
                FR_DATA: begin
                    if (frameMark) begin
                        state_r <= FR_IDLE;
                    end
                end
                default: begin
                    if (frameMark) begin
                        state_r <= FR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hdrIdx_r <= 2'h0;
            cmd_r <= 4'h0;
            addr_r <= 20'h00000;
        end else if (state_r != FR_HDR) begin
            hdrIdx_r <= 2'h0;
            if (wrEn) begin
                addr_r <= addr_r + 20'h00001;
            end
        end else if (byteDone) begin
            hdrIdx_r <= hdrIdx_r + 2'h1;
            case (hdrIdx_r)
                2'h0: begin
                    cmd_r <= byteData[7:4];
                    addr_r[19:16] <= byteData[3:0];
                end
                2'h1: addr_r[15:8] <= byteData;
                2'h2: addr_r[7:0] <= byteData;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // monitored configuration registers

    link_rate_e rate_r;
    logic [4:0] laneField_r;
    logic [1:0] swing_r;
    logic [1:0] pre_r;
    logic standby_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rate_r <= RATE_270;
        end else if (wrEn && wrAddr == `ADDR_LINK_RATE) begin
            if (wrData == `RATE_WR_162) begin
                rate_r <= RATE_162;
            end else if (wrData == `RATE_WR_270) begin
                rate_r <= RATE_270;
            end else begin
                rate_r <= RATE_540;
            end
        end
    end

    // bits above the lane count field are reserved and dropped
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            laneField_r <= `LANE_COUNT_RESET;
        end else if (wrEn && wrAddr == `ADDR_LANE_COUNT) begin
            laneField_r <= wrData[`LANE_COUNT_MSB:0];
        end
    end

    // bit 2 and bits 7:5 are reserved and never stored
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            swing_r <= `DRIVE_LEVEL_RESET;
            pre_r <= `DRIVE_LEVEL_RESET;
        end else if (wrEn && wrAddr == `ADDR_LANE0_DRIVE) begin
            swing_r <= wrData[`SWING_MSB:`SWING_LSB];
            pre_r <= wrData[`PRE_MSB:`PRE_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            standby_r <= 1'b0;
        end else if (wrEn && wrAddr == `ADDR_POWER_STATE) begin
            if (wrData[2:0] == `POWER_D3) begin
                standby_r <= 1'b1;
            end else if (wrData[2:0] == `POWER_D0) begin
                standby_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // derived settings

    logic comboBad;
    logic [3:0] laneMask;
    logic [7:0] laneCode;
    logic [7:0] rateCode;

    // the five forbidden pairs: 01/11, and any with both levels two or more;
    // 11/01 sums above three yet stays a permitted setting
    assign comboBad = (swing_r == 2'h1 && pre_r == 2'h3) || (swing_r[1] && pre_r[1]);

    always_comb begin
        laneMask = 4'h0;
        laneCode = `LANES_RD_0;
        if (laneField_r == `LANES_WR_1) begin
            laneMask = 4'h1;
            laneCode = `LANES_RD_1;
        end else if (laneField_r == `LANES_WR_2) begin
            laneMask = 4'h3;
            laneCode = `LANES_RD_2;
        end else if (laneField_r == `LANES_WR_4) begin
            laneMask = 4'hF;
            laneCode = `LANES_RD_4;
        end
    end

    always_comb begin
        case (rate_r)
            RATE_162: rateCode = `RATE_RD_162;
            RATE_270: rateCode = `RATE_RD_270;
            default: rateCode = `RATE_RD_540;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            linkRateSelect <= RATE_270;
            linkRateReadCode <= `RATE_RD_270;
            laneCountReadCode <= `LANES_RD_0;
            lane0ReadCode <= 8'h00;
            laneEnable <= 4'h0;
            outputSwingLevel <= `DRIVE_LEVEL_RESET;
            preEmphasisLevel <= `DRIVE_LEVEL_RESET;
            inputEqualizerSetting <= `DRIVE_LEVEL_RESET;
            standbyRequest <= 1'b0;
            tmdsMode <= 1'b0;
            monitorActive <= 1'b0;
        end else begin
            linkRateSelect <= rate_r;
            linkRateReadCode <= rateCode;
            laneCountReadCode <= laneCode;
            lane0ReadCode <= {4'h0, pre_r, swing_r};
            laneEnable <= comboBad ? 4'h0 : laneMask;
            outputSwingLevel <= swing_r;
            preEmphasisLevel <= pre_r;
            inputEqualizerSetting <= pre_r;
            standbyRequest <= standby_r;
            tmdsMode <= tmdsNow;
            monitorActive <= !tmdsNow;
        end
    end

    ////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_laneBadWrite;
        wrEn && wrAddr == `ADDR_LANE_COUNT && wrData[4:0] != `LANES_WR_0 &&
            wrData[4:0] != `LANES_WR_1 && wrData[4:0] != `LANES_WR_2 &&
            wrData[4:0] != `LANES_WR_4;
    endsequence

    sequence s_rateOddWrite;
        wrEn && wrAddr == `ADDR_LINK_RATE && wrData != `RATE_WR_162 &&
            wrData != `RATE_WR_270;
    endsequence

    sequence s_d3Write;
        wrEn && wrAddr == `ADDR_POWER_STATE && wrData[2:0] == `POWER_D3;
    endsequence

    property p_tmds_quiet;
        tmdsNow |=> state_r == FR_IDLE && !wrEn && !monitorActive;
    endproperty
    a_tmds_quiet: assert property (p_tmds_quiet)
        else $error("monitor active during TMDS mode");

    property p_rate_fallback;
        s_rateOddWrite |=> rate_r == RATE_540 ##1 linkRateReadCode == `RATE_RD_540;
    endproperty
    a_rate_fallback: assert property (p_rate_fallback)
        else $error("link rate did not fall back to 5.4");

    property p_rate_162;
        wrEn && wrAddr == `ADDR_LINK_RATE && wrData == `RATE_WR_162
            |=> ##1 linkRateSelect == RATE_162 && linkRateReadCode == `RATE_RD_162;
    endproperty
    a_rate_162: assert property (p_rate_162)
        else $error("1.62 rate code not applied");

    property p_lane_invalid;
        s_laneBadWrite |=> ##1 laneEnable == 4'h0 && laneCountReadCode == `LANES_RD_0;
    endproperty
    a_lane_invalid: assert property (p_lane_invalid)
        else $error("invalid lane count left lanes on");

    property p_lane_four;
        laneField_r == `LANES_WR_4 && !comboBad
            |=> laneEnable == 4'hF && laneCountReadCode == `LANES_RD_4;
    endproperty
    a_lane_four: assert property (p_lane_four)
        else $error("four lane setting not shown");

    property p_combo_disable;
        comboBad |=> laneEnable == 4'h0;
    endproperty
    a_combo_disable: assert property (p_combo_disable)
        else $error("forbidden drive pair left lanes on");

    property p_drive_capture;
        wrEn && wrAddr == `ADDR_LANE0_DRIVE |=> ##1
            lane0ReadCode == {4'h0, $past(wrData[4:3], 2), $past(wrData[1:0], 2)};
    endproperty
    a_drive_capture: assert property (p_drive_capture)
        else $error("lane-0 readback does not match write");

    property p_eq_from_pre;
        $changed(swing_r) && $stable(pre_r) |=> $stable(inputEqualizerSetting);
    endproperty
    a_eq_from_pre: assert property (p_eq_from_pre)
        else $error("equalizer moved with swing");

    property p_standby;
        s_d3Write |=> ##1 standbyRequest;
    endproperty
    a_standby: assert property (p_standby)
        else $error("D3 write did not raise standby");

endmodule

// >>> verification/aux_source_model.sv
// Purpose: behavioural AUX source that sends Manchester request frames
// Assumes: 40 cycles of clk_sys per AUX bit
// Notes: line rests low between frames; frameDone pulses after the idle gap
`timescale 1ns/1ps
module aux_source_model (
    input wire logic clk_sys,
    output logic auxLine,
    output logic frameDone
);
    initial begin
        auxLine = 1'b0;
        frameDone = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic hold(input logic v, input int n);
        auxLine = v;
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    // value is the second-half level, so every bit has a mid-bit edge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            hold(~b[i], 20);
            hold(b[i], 20);
        end
    endtask

    // a gap longer than the quiet limit puts the snooper back to idle
    task automatic send_frame(input logic [3:0] cmd, input logic [19:0] a,
        input logic [7:0] d0, input logic [7:0] d1, input int n, input int gap);
        @(posedge clk_sys);
        #2;
        send_byte(8'h00);
        hold(1'b1, 80);
        hold(1'b0, 80);
        send_byte({cmd, a[19:16]});
        send_byte(a[15:8]);
        send_byte(a[7:0]);
        send_byte(8'(n - 1));
        send_byte(d0);
        if (n > 1) begin
            send_byte(d1);
        end
        hold(1'b1, 80);
        hold(1'b0, gap);
        frameDone = 1'b1;
        @(posedge clk_sys);
        #2;
        frameDone = 1'b0;
    endtask
endmodule

// >>> verification/aux_link_training_monitor_test.sv
// Purpose: self-checking bench for the AUX link training monitor
// Assumes: expected state is rebuilt here from every snooped write
// Notes: outputs are sampled on the falling edge, clear of updates
`timescale 1ns/1ps
`include "aux_monitor_cfg.svh"
module aux_link_training_monitor_test;
    import aux_monitor_pkg::*;
    logic clk_sys, rst_b, auxLine, frameDone, benchStrobe;
    logic cableAdapterDetectInput, tmdsTestForce;
    link_rate_e linkRateSelect, mRate;
    logic [7:0] linkRateReadCode, laneCountReadCode, lane0ReadCode;
    logic [3:0] laneEnable;
    logic [1:0] outputSwingLevel, preEmphasisLevel, inputEqualizerSetting, mSwing, mPre;
    logic standbyRequest, tmdsMode, monitorActive, mStandby;
    logic [4:0] mLanes;
    logic [38:0] notes[$];
    logic [38:0] got, exp;
    logic [31:0] rnd = 32'd72591;
    int errCount = 0, samplesChecked = 0, cycles = 0;

    aux_source_model src (.clk_sys(clk_sys), .auxLine(auxLine), .frameDone(frameDone));

    aux_link_training_monitor dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .auxLineIn(auxLine),
        .cableAdapterDetectInput(cableAdapterDetectInput), .tmdsTestForce(tmdsTestForce),
        .linkRateSelect(linkRateSelect), .linkRateReadCode(linkRateReadCode),
        .laneCountReadCode(laneCountReadCode), .lane0ReadCode(lane0ReadCode),
        .laneEnable(laneEnable), .outputSwingLevel(outputSwingLevel),
        .preEmphasisLevel(preEmphasisLevel), .inputEqualizerSetting(inputEqualizerSetting),
        .standbyRequest(standbyRequest), .tmdsMode(tmdsMode), .monitorActive(monitorActive)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samplesChecked++;
        if (seen !== want) begin
            errCount++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [38:0] predict();
        logic [7:0] rc, lc;
        logic [3:0] mask;
        logic tm;
        rc = (mRate == RATE_162) ? 8'h00 : (mRate == RATE_270) ? 8'h01 : 8'h02;
        case (mLanes)
            5'h01: begin lc = 8'h01; mask = 4'h1; end
            5'h02: begin lc = 8'h03; mask = 4'h3; end
            5'h04: begin lc = 8'h05; mask = 4'hF; end
            default: begin lc = 8'h00; mask = 4'h0; end
        endcase
        // listed forbidden swing/pre pairs; 11/01 stays allowed
        case ({mSwing, mPre})
            4'h7, 4'hA, 4'hB, 4'hE, 4'hF: mask = 4'h0;
            default: ;
        endcase
        tm = cableAdapterDetectInput | tmdsTestForce;
        return {mRate, rc, lc, {4'h0, mPre, mSwing}, mask, mSwing, mPre, mPre,
            mStandby, tm, ~tm};
    endfunction

    task automatic model_reset();
        mRate = RATE_270;
        mLanes = 5'h00;
        mSwing = 2'h0;
        mPre = 2'h0;
        mStandby = 1'b0;
    endtask

    task automatic apply(input logic [19:0] a, input logic [7:0] d);
        case (a)
            `ADDR_LINK_RATE: mRate = (d == 8'h06) ? RATE_162 : (d == 8'h0A) ? RATE_270 : RATE_540;
            `ADDR_LANE_COUNT: mLanes = d[4:0];
            `ADDR_LANE0_DRIVE: begin mSwing = d[1:0]; mPre = d[4:3]; end
            `ADDR_POWER_STATE: begin
                if (d[2:0] == `POWER_D3) mStandby = 1'b1;
                else if (d[2:0] == `POWER_D0) mStandby = 1'b0;
            end
            default: ;
        endcase
    endtask

    task automatic wr(input logic [3:0] cmd, input logic [19:0] a, input logic [7:0] d0,
        input logic [7:0] d1, input int n);
        if (cmd == `CMD_NATIVE_WRITE && !(cableAdapterDetectInput || tmdsTestForce)) begin
            apply(a, d0);
            if (n > 1) apply(a + 20'h1, d1);
        end
        notes.push_back(predict());
        src.send_frame(cmd, a, d0, d1, n, (n > 1) ? 400 : 170);
    endtask

    task automatic expect_now();
        notes.push_back(predict());
        benchStrobe = 1'b1;
        @(posedge clk_sys);
        #2;
        benchStrobe = 1'b0;
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        model_reset();
        repeat (10) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        repeat (5) @(posedge clk_sys);
        #2;
        expect_now();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys) begin
        if (frameDone || benchStrobe) begin
            got = {linkRateSelect, linkRateReadCode, laneCountReadCode, lane0ReadCode,
                laneEnable, outputSwingLevel, preEmphasisLevel, inputEqualizerSetting,
                standbyRequest, tmdsMode, monitorActive};
            exp = (notes.size() > 0) ? notes.pop_front() : ~got;
            check(16'(got[38:29]), 16'(exp[38:29]));
            check({got[28:21], got[12:9]}, {exp[28:21], exp[12:9]});
            check({got[20:13], got[8:3]}, {exp[20:13], exp[8:3]});
            check(16'(got[2]), 16'(exp[2]));
            check(16'(got[1:0]), 16'(exp[1:0]));
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 95000) begin
            errCount++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] rates[6] = '{8'h06, 8'h14, 8'h0A, 8'h00, 8'hFF, 8'h15};
        logic [7:0] lanes[6] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'hE2, 8'h00};
        rst_b = 1'b0;
        benchStrobe = 1'b0;
        cableAdapterDetectInput = 1'b0;
        tmdsTestForce = 1'b0;
        do_reset();
        foreach (rates[i]) wr(`CMD_NATIVE_WRITE, `ADDR_LINK_RATE, rates[i], lanes[i], 2);
        // four lanes on first, so a forbidden pair has lanes to switch off
        wr(`CMD_NATIVE_WRITE, `ADDR_LANE_COUNT, 8'h04, 8'h00, 1);
        for (int p = 0; p < 16; p++) begin
            // reserved bits 7:5 written as 101b and bit 2 set to show they are ignored
            wr(`CMD_NATIVE_WRITE, `ADDR_LANE0_DRIVE, {3'h5, p[1:0], 1'b1, p[3:2]}, 8'h00, 1);
        end
        for (int k = 0; k < 3; k++) begin
            rnd = xorshift(rnd);
            wr(`CMD_NATIVE_WRITE, `ADDR_LINK_RATE, rnd[7:0], rnd[15:8], 2);
            wr(`CMD_NATIVE_WRITE, `ADDR_LANE0_DRIVE, rnd[23:16], 8'h00, 1);
        end
        wr(`CMD_NATIVE_WRITE, `ADDR_POWER_STATE, 8'h02, 8'h00, 1);
        wr(`CMD_NATIVE_WRITE, `ADDR_POWER_STATE, 8'h05, 8'h00, 1);
        wr(4'h9, `ADDR_LINK_RATE, 8'h06, 8'h00, 1);
        wr(`CMD_NATIVE_WRITE, `ADDR_POWER_STATE, 8'h01, 8'h00, 1);
        cableAdapterDetectInput = 1'b1;
        repeat (10) @(posedge clk_sys);
        #2;
        wr(`CMD_NATIVE_WRITE, `ADDR_LINK_RATE, 8'h06, 8'h00, 1);
        cableAdapterDetectInput = 1'b0;
        tmdsTestForce = 1'b1;
        repeat (10) @(posedge clk_sys);
        #2;
        wr(`CMD_NATIVE_WRITE, `ADDR_LANE_COUNT, 8'h01, 8'h00, 1);
        tmdsTestForce = 1'b0;
        repeat (10) @(posedge clk_sys);
        #2;
        expect_now();
        do_reset();
        repeat (5) @(posedge clk_sys);
        if (notes.size() != 0) errCount++;
        stop_test();
    end
endmodule
